//--- core/crank_speed_direction_core.v
// Digital core of a differential speed and direction sensor with APB access
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "crank_core_regs.vh"

module crank_speed_direction_core #(
  parameter [15:0] POWERON_CYCLES = `PON_CYCLES,
  parameter SW = 12
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Configuration memory loader
  input wire nvmDone,
  input wire nvmError,
  input wire [31:0] nvmConfig,
  // ADC samples of speed and direction channels
  input wire sampleValid,
  input wire [SW-1:0] speedSample,
  input wire [SW-1:0] dirSample,
  // Open-drain output pin
  output reg qOut_q,
  output reg qOeN_q
);

  localparam [2:0] PH_PON = 3'h0;
  localparam [2:0] PH_INIT = 3'h1;
  localparam [2:0] PH_CAL1 = 3'h2;
  localparam [2:0] PH_CAL2 = 3'h3;
  localparam [2:0] PH_RUN = 3'h4;
  localparam [2:0] PH_LOCK = 3'h5;

  localparam integer FWD_I = (`T_FWD_US * `CLK_KHZ) / 1000;
  localparam integer BWD_I = (`T_BWD_US * `CLK_KHZ) / 1000;
  localparam integer OPT_I = (`T_BWD_OPT_US * `CLK_KHZ) / 1000;
  localparam [11:0] FWD_CYC = FWD_I[11:0];
  localparam [11:0] BWD_CYC = BWD_I[11:0];
  localparam [11:0] OPT_CYC = OPT_I[11:0];

  function [15:0] absv;
    input [15:0] v;
    begin
      absv = v[15] ? (16'h0000 - v) : v;
    end
  endfunction

  function [15:0] midpt;
    input [15:0] a;
    input [15:0] b;
    reg [16:0] s;
    begin
      s = {a[15], a} + {b[15], b};
      midpt = s[16:1];
    end
  endfunction

  // Registers
  reg [`CFG_W-1:0] cfg_q;
  reg [11:0] floor_q;
  reg [2:0] phase_q;
  reg [15:0] ponCnt_q;
  reg signed [15:0] thr_q;
  reg signed [15:0] max_q;
  reg signed [15:0] min_q;
  reg signed [15:0] peak_q;
  reg trackUp_q;
  reg haveMax_q;
  reg haveMin_q;
  reg above_q;
  reg armRise_q;
  reg armFall_q;
  reg [2:0] edgeCnt_q;
  reg [1:0] switchCnt_q;
  reg signed [23:0] sum_q;
  reg [7:0] updCnt_q;
  reg sgnFirst_q;
  reg sgnOk_q;
  reg lastValid_q;
  reg lastNeg_q;
  reg pair_q;
  reg signed [15:0] dirFirst_q;
  reg [15:0] dirAvg_q;
  reg [15:0] dirThr_q;
  reg back_q;
  reg dirValid_q;
  reg revSeen_q;
  reg firstDone_q;
  reg pulse_q;
  reg [11:0] pcnt_q;
  reg [11:0] plen_q;

  // Sample view and hysteresis levels
  wire signed [15:0] sp = {{(16-SW){speedSample[SW-1]}}, speedSample};
  wire signed [15:0] ds = {{(16-SW){dirSample[SW-1]}}, dirSample};
  wire active = (phase_q == PH_CAL1) || (phase_q == PH_CAL2) ||
    (phase_q == PH_RUN);
  wire ev = sampleValid & active;
  wire signed [15:0] ppk = max_q - min_q;
  wire signed [15:0] hystAdapt = (ppk >>> 2) +
    (cfg_q[`CFG_HOPT] ? (ppk >>> 4) : 16'sh0000);
  wire signed [15:0] floorS = {4'h0, floor_q};
  wire [1:0] hMode = cfg_q[`CFG_HMODE+1:`CFG_HMODE];
  wire signed [15:0] hyst = (hMode == `HMODE_FIXED ||
    hystAdapt < floorS) ? floorS : hystAdapt;
  wire signed [15:0] halfH = hyst >>> 1;
  wire signed [15:0] upper = thr_q + halfH;
  wire signed [15:0] lower = thr_q - halfH;
  // Visible hysteresis moves the switch points out to the levels
  wire visible = (hMode == `HMODE_VISIBLE);
  wire signed [15:0] lvlR = visible ? upper : thr_q;
  wire signed [15:0] lvlF = visible ? lower : thr_q;

  // Extrema and zero crossings
  wire evMax = ev & trackUp_q & (sp < peak_q - hyst);
  wire evMin = ev & ~trackUp_q & (sp > peak_q + hyst);
  wire evEdge = evMax | evMin;
  wire signed [15:0] midNow = evMax ? midpt(peak_q, min_q) :
    midpt(max_q, peak_q);
  wire zcR = ev & ~above_q & armRise_q & (sp >= lvlR);
  wire zcF = ev & above_q & armFall_q & (sp < lvlF);
  wire zc = zcR | zcF;
  // Rising speed crossing is tooth middle
  wire selRise = cfg_q[`CFG_EDGE] ^ cfg_q[`CFG_FWD];
  wire early = (phase_q == PH_CAL1) && (switchCnt_q < 2'h2);
  wire fire = early ? (selRise ? evMin : evMax) :
    (selRise ? zcR : zcF);

  // Offset update path
  wire [1:0] algo = cfg_q[`CFG_ALGO+1:`CFG_ALGO];
  wire [7:0] winLen = (algo == `ALGO_32) ? `WIN_32 :
    (algo == `ALGO_SIGN) ? `WIN_SIGN : `WIN_58;
  wire [16:0] recip = (algo == `ALGO_32) ? `RECIP_32 :
    (algo == `ALGO_SIGN) ? `RECIP_SIGN : `RECIP_58;
  wire signed [23:0] sumNext = sum_q + {{8{midNow[15]}}, midNow};
  wire signed [41:0] prod = sumNext * $signed({1'b0, recip});
  wire signed [15:0] avg = prod[31:16];
  wire signed [15:0] delta = avg - thr_q;
  wire neg = delta[15];
  wire [15:0] mag = absv(delta);
  wire [15:0] aMax = absv(max_q);
  wire [15:0] aMin = absv(min_q);
  wire [15:0] absPeak = (aMax > aMin) ? aMax : aMin;
  wire [15:0] ampLim = ppk[15] ? 16'h0000 : (ppk >>> 3);
  wire [15:0] absLim = absPeak >> 3;
  wire [15:0] maxUpd = (ampLim < absLim) ? ampLim : absLim;
  wire [15:0] clampM = (mag > maxUpd) ? maxUpd : mag;
  wire [15:0] halfU = clampM >> 1;
  wire signed [15:0] step = neg ? (16'sh0000 - halfU) : halfU;
  wire winDone = evEdge && (updCnt_q == winLen - 8'h01);
  wire curSign = (midNow < thr_q);
  wire signOk = sgnOk_q & ((updCnt_q == 8'h00) | (curSign == sgnFirst_q));
  // Maximum ends a rising edge, so only an upward move fits it
  wire edgeBad = evMax ? neg : (~neg & (delta != 16'sh0000));
  wire accept = winDone & ~edgeBad & (mag >= `MIN_UPD) &
    ((algo != `ALGO_SIGN) | signOk) &
    ~(lastValid_q & (lastNeg_q != neg));
  wire [2:0] edgesNext = edgeCnt_q + 3'h1;
  wire bothSeen = (haveMax_q | evMax) & (haveMin_q | evMin);
  wire cal1Done = evEdge && ((edgesNext >= `CAL1_EDGES && bothSeen) ||
    edgesNext >= `CAL1_EDGES_MAX);

  // Direction path
  wire signed [15:0] dDiff = dirFirst_q - ds;
  wire [15:0] dMag = absv(dDiff);
  wire [15:0] avgStep = dMag - dirAvg_q;
  wire [15:0] dirAvgNext = dirValid_q ?
    (dirAvg_q + {{2{avgStep[15]}}, avgStep[15:2]}) : dMag;
  wire [15:0] dirThrNext = cfg_q[`CFG_DIRTHR] ? (dirAvgNext >> 3) :
    (dirAvgNext >> 2);
  wire dirRev = dirValid_q & (dMag < dirThr_q);

  // Phase sequencer, extrema tracking and threshold adaptation
  always @(posedge clk_sys) begin
    if (rst) begin
      phase_q <= PH_PON;
      ponCnt_q <= 16'h0000;
      thr_q <= 16'sh0000;
      max_q <= 16'sh0000;
      min_q <= 16'sh0000;
      peak_q <= 16'sh0000;
      trackUp_q <= 1'b1;
      haveMax_q <= 1'b0;
      haveMin_q <= 1'b0;
      above_q <= 1'b0;
      armRise_q <= 1'b0;
      armFall_q <= 1'b0;
      edgeCnt_q <= 3'h0;
      switchCnt_q <= 2'h0;
      sum_q <= 24'sh000000;
      updCnt_q <= 8'h00;
      sgnFirst_q <= 1'b0;
      sgnOk_q <= 1'b1;
      lastValid_q <= 1'b0;
      lastNeg_q <= 1'b0;
    end else begin
      case (phase_q)
        PH_PON: begin
          if (ponCnt_q != POWERON_CYCLES) begin
            ponCnt_q <= ponCnt_q + 16'h0001;
          end else if (nvmDone) begin
            phase_q <= nvmError ? PH_LOCK : PH_INIT;
          end
        end
        PH_INIT: begin
          // One cycle only: arm tracking and enter calibration
          trackUp_q <= 1'b1;
          peak_q <= 16'sh0000;
          armRise_q <= 1'b1;
          armFall_q <= 1'b1;
          phase_q <= PH_CAL1;
        end
        PH_LOCK: begin
          phase_q <= PH_LOCK;
        end
        default: begin
          if (ev) begin
            if (trackUp_q) begin
              if (evMax) begin
                max_q <= peak_q;
                haveMax_q <= 1'b1;
                trackUp_q <= 1'b0;
                peak_q <= sp;
              end else if (sp > peak_q) begin
                peak_q <= sp;
              end
            end else begin
              if (evMin) begin
                min_q <= peak_q;
                haveMin_q <= 1'b1;
                trackUp_q <= 1'b1;
                peak_q <= sp;
              end else if (sp < peak_q) begin
                peak_q <= sp;
              end
            end
            // Lower crossing always arms the rise, upper or not
            if (sp < lower) begin
              armRise_q <= 1'b1;
            end else if (zcR) begin
              armRise_q <= 1'b0;
            end
            if (sp > upper) begin
              armFall_q <= 1'b1;
            end else if (zcF) begin
              armFall_q <= 1'b0;
            end
            if (zcR) begin
              above_q <= 1'b1;
            end else if (zcF) begin
              above_q <= 1'b0;
            end
            if (fire && switchCnt_q != 2'h3) begin
              switchCnt_q <= switchCnt_q + 2'h1;
            end
          end
          if (phase_q == PH_CAL1) begin
            if (evEdge) begin
              edgeCnt_q <= edgesNext;
              if (bothSeen) begin
                thr_q <= midNow;
              end
            end
            if (cal1Done) begin
              phase_q <= PH_CAL2;
              sum_q <= 24'sh000000;
              updCnt_q <= 8'h00;
              sgnOk_q <= 1'b1;
            end
          end else if (evEdge) begin
            if (updCnt_q == 8'h00) begin
              sgnFirst_q <= curSign;
            end
            if (winDone) begin
              sum_q <= 24'sh000000;
              updCnt_q <= 8'h00;
              sgnOk_q <= 1'b1;
              lastValid_q <= accept;
              if (accept) begin
                thr_q <= thr_q + step;
                lastNeg_q <= neg;
              end
              if (phase_q == PH_CAL2) begin
                phase_q <= PH_RUN;
              end
            end else begin
              sum_q <= sumNext;
              updCnt_q <= updCnt_q + 8'h01;
              sgnOk_q <= signOk;
            end
          end
        end
      endcase
    end
  end

  // Direction detection from direction samples at speed crossings
  always @(posedge clk_sys) begin
    if (rst) begin
      pair_q <= 1'b0;
      dirFirst_q <= 16'sh0000;
      dirAvg_q <= 16'h0000;
      dirThr_q <= 16'h0000;
      back_q <= 1'b0;
      dirValid_q <= 1'b0;
      revSeen_q <= 1'b0;
    end else if (zc) begin
      if (!pair_q) begin
        dirFirst_q <= ds;
        pair_q <= 1'b1;
      end else begin
        pair_q <= 1'b0;
        dirAvg_q <= dirAvgNext;
        dirThr_q <= dirThrNext;
        dirValid_q <= 1'b1;
        if (dirRev) begin
          // Swing below threshold: wheel turned back between samples
          back_q <= ~back_q;
          revSeen_q <= 1'b1;
        end else begin
          back_q <= dDiff[15] ^ cfg_q[`CFG_FWD];
        end
      end
    end
  end

  // Output pulse generation on the open-drain pin
  always @(posedge clk_sys) begin
    if (rst) begin
      qOut_q <= 1'b0;
      qOeN_q <= 1'b1;
      pulse_q <= 1'b0;
      pcnt_q <= 12'h000;
      plen_q <= FWD_CYC;
      firstDone_q <= 1'b0;
    end else if (!active) begin
      qOeN_q <= 1'b1;
      pulse_q <= 1'b0;
    end else if (!cfg_q[`CFG_DIREN]) begin
      // Without direction the pin follows the wheel profile
      if (zcR) begin
        qOeN_q <= cfg_q[`CFG_EDGE];
      end else if (zcF) begin
        qOeN_q <= ~cfg_q[`CFG_EDGE];
      end
      pulse_q <= 1'b0;
    end else if (pulse_q) begin
      if (pcnt_q == plen_q - 12'h001) begin
        qOeN_q <= 1'b1;
        pulse_q <= 1'b0;
      end else begin
        pcnt_q <= pcnt_q + 12'h001;
      end
    end else if (fire) begin
      qOeN_q <= 1'b0;
      pulse_q <= 1'b1;
      pcnt_q <= 12'h000;
      firstDone_q <= 1'b1;
      if (!firstDone_q || !dirValid_q || !back_q) begin
        plen_q <= FWD_CYC;
      end else begin
        plen_q <= cfg_q[`CFG_OPTPROT] ? OPT_CYC : BWD_CYC;
      end
    end
  end

  // APB slave: no wait states, read data captured in the setup cycle
  wire apbWrite = psel & penable & pready & pwrite;
  always @(posedge clk_sys) begin
    if (rst) begin
      cfg_q <= `CFG_RESET;
      floor_q <= `FLOOR_RESET;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      // Error flag stands only with pready, never past the access cycle
      pslverr <= 1'b0;
      if (phase_q == PH_PON && ponCnt_q == POWERON_CYCLES && nvmDone) begin
        cfg_q <= nvmConfig[`CFG_W-1:0];
        floor_q <= nvmConfig[27:16];
      end else if (apbWrite && paddr == `REG_CFG) begin
        cfg_q <= pwdata[`CFG_W-1:0];
      end else if (apbWrite && paddr == `REG_HYST) begin
        floor_q <= pwdata[11:0];
      end
      if (psel && !penable) begin
        pslverr <= 1'b0;
        if (paddr == `REG_CFG) begin
          prdata <= {22'h000000, cfg_q};
        end else if (paddr == `REG_HYST) begin
          prdata <= {20'h00000, floor_q};
        end else if (paddr == `REG_STATUS) begin
          prdata <= {dirThr_q, 3'h0, edgeCnt_q, switchCnt_q, firstDone_q,
            revSeen_q, dirValid_q, back_q, phase_q == PH_LOCK, phase_q};
        end else if (paddr == `REG_THR) begin
          prdata <= {ppk, thr_q};
        end else begin
          prdata <= 32'h00000000;
          pslverr <= 1'b1;
        end
      end
    end
  end

endmodule // crank_speed_direction_core
`default_nettype wire

//--- core/crank_core_regs.vh
// Register map, field positions, reset values and timing for the crank core
`ifndef CRANK_CORE_REGS_VH
`define CRANK_CORE_REGS_VH

`define REG_CFG 8'h00
`define REG_HYST 8'h04
`define REG_STATUS 8'h08
`define REG_THR 8'h0c

`define CFG_EDGE 0
`define CFG_FWD 1
`define CFG_DIREN 2
`define CFG_OPTPROT 3
`define CFG_DIRTHR 4
`define CFG_HMODE 5
`define CFG_HOPT 7
`define CFG_ALGO 8
`define CFG_W 10
`define CFG_RESET 10'h004
`define FLOOR_RESET 12'h010

`define HMODE_HIDDEN 2'h0
`define HMODE_VISIBLE 2'h1
`define HMODE_FIXED 2'h2
`define ALGO_58 2'h0
`define ALGO_32 2'h1
`define ALGO_SIGN 2'h2

`define WIN_58 8'h74
`define WIN_32 8'h40
`define WIN_SIGN 8'h0a
`define RECIP_58 17'h00235
`define RECIP_32 17'h00400
`define RECIP_SIGN 17'h0199a
`define CAL1_EDGES 3'h3
`define CAL1_EDGES_MAX 3'h4
`define MIN_UPD 16'h0002

`define CLK_KHZ 32'h61a8
`define T_FWD_US 32'h2d
`define T_BWD_US 32'h5a
`define T_BWD_OPT_US 32'h87
`define PON_CYCLES 16'h09c4

`endif

//--- verification/ecu_pulse_reader.sv
// Engine controller model: pulled-up pin and low pulse timer
`timescale 1ns/1ps
`default_nettype none
module ecu_pulse_reader (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Open-drain pin from the core
  input wire logic qOut_q,
  input wire logic qOeN_q,
  // Decoded pulses
  output var logic pinLevel,
  output var logic [15:0] lastLen,
  output var logic [15:0] pulseCnt
);
  logic [15:0] lowCnt_q;
  // Pull-up wins whenever the core releases the pin
  assign pinLevel = qOeN_q ? 1'b1 : qOut_q;
  always @(posedge clk_sys) begin
    if (rst) begin
      lowCnt_q <= 16'h0000;
      lastLen <= 16'h0000;
      pulseCnt <= 16'h0000;
    end else if (!pinLevel) begin
      lowCnt_q <= lowCnt_q + 16'h0001;
    end else if (lowCnt_q != 16'h0000) begin
      lastLen <= lowCnt_q;
      pulseCnt <= pulseCnt + 16'h0001;
      lowCnt_q <= 16'h0000;
    end
  end
endmodule // ecu_pulse_reader
`default_nettype wire

//--- verification/crank_core_sva.sv
// Concurrent checks on the crank core ports
`timescale 1ns/1ps
`default_nettype none
module crank_core_checker #(
  parameter [15:0] POWERON_CYCLES = 16'h0004,
  parameter SW = 12
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Loader and samples
  input wire logic nvmDone,
  input wire logic nvmError,
  input wire logic sampleValid,
  // Pin
  input wire logic qOut_q,
  input wire logic qOeN_q
);
  localparam logic [11:0] LEN_FWD = 12'h465;
  localparam logic [11:0] LEN_BWD = 12'h8ca;
  localparam logic [11:0] LEN_OPT = 12'hd2f;
  logic [11:0] lowCnt_q;
  logic errSeen_q;
  logic pulseSeen_q;
  always @(posedge clk_sys) begin
    if (rst) begin
      lowCnt_q <= 12'h000;
      errSeen_q <= 1'b0;
      pulseSeen_q <= 1'b0;
    end else begin
      lowCnt_q <= qOeN_q ? 12'h000 : lowCnt_q + 12'h001;
      errSeen_q <= errSeen_q | (nvmDone & nvmError);
      pulseSeen_q <= pulseSeen_q | $rose(qOeN_q);
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside an access cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  unmapped_err_a: assert property (psel && !penable && paddr > 8'h0c
    |=> pslverr) else $error("unmapped access without error");
  mapped_ok_a: assert property (psel && !penable && paddr <= 8'h0c &&
    paddr[1:0] == 2'b00 |=> !pslverr) else $error("mapped access errored");
  pulse_len_a: assert property ($rose(qOeN_q) |-> lowCnt_q == LEN_FWD ||
    lowCnt_q == LEN_BWD || lowCnt_q == LEN_OPT) else $error("bad pulse");
  low_bound_a: assert property (!qOeN_q |-> lowCnt_q < LEN_OPT)
    else $error("pin held low too long");
  first_fwd_a: assert property ($rose(qOeN_q) && !pulseSeen_q
    |-> lowCnt_q == LEN_FWD) else $error("first pulse not forward");
  lock_high_a: assert property (errSeen_q |-> qOeN_q)
    else $error("pin switched after load error");
  // Repeat count matches the shortened power-on used in simulation
  poweron_high_a: assert property ($fell(rst) |-> qOeN_q [*4])
    else $error("pin low during power-on");
  fall_cause_a: assert property ($fell(qOeN_q)
    |-> $past(sampleValid) || $past(sampleValid, 2))
    else $error("pin fell without a sample");
  drive_zero_a: assert property (qOut_q == 1'b0)
    else $error("open-drain value not low");
  cover property ($rose(qOeN_q) && lowCnt_q == LEN_BWD);
  cover property ($rose(qOeN_q) && lowCnt_q == LEN_OPT);
  cover property (pslverr);
endmodule // crank_core_checker
bind crank_speed_direction_core crank_core_checker #(
  .POWERON_CYCLES(POWERON_CYCLES),
  .SW(SW)
) chk (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .nvmDone(nvmDone),
  .nvmError(nvmError), .sampleValid(sampleValid), .qOut_q(qOut_q),
  .qOeN_q(qOeN_q)
);
`default_nettype wire

//--- verification/tb_crank_speed_direction_core.sv
// Testbench for the crank core: APB tasks and a toothed wheel source
`timescale 1ns/1ps
`default_nettype none
`include "crank_core_regs.vh"
module tb_crank_speed_direction_core;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr;
  logic nvmDone, nvmError, sampleValid, qOut_q, qOeN_q, pinLevel;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, nvmConfig, rdData;
  logic [11:0] speedSample, dirSample;
  logic [15:0] lastLen, pulseCnt, l0;
  logic genOn = 1'b0, riseNow = 1'b0, fallRise, rdErr;
  logic [5:0] gap = 6'h00, idx = 6'h00;
  int errors = 0, totalChecks = 0;

  crank_speed_direction_core #(.POWERON_CYCLES(16'h0004), .SW(12)) dut (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .nvmDone(nvmDone),
    .nvmError(nvmError), .nvmConfig(nvmConfig), .sampleValid(sampleValid),
    .speedSample(speedSample), .dirSample(dirSample), .qOut_q(qOut_q),
    .qOeN_q(qOeN_q));
  ecu_pulse_reader ecu (.clk_sys(clk_sys), .rst(rst), .qOut_q(qOut_q),
    .qOeN_q(qOeN_q), .pinLevel(pinLevel), .lastLen(lastLen),
    .pulseCnt(pulseCnt));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Triangle wave, 800 peak-to-peak; direction leads speed by a quarter
  function automatic logic [11:0] wave(input logic [5:0] i);
    int v;
    v = i[5] ? 1200 - 25 * int'(i) : 25 * int'(i) - 400;
    return v[11:0];
  endfunction

  // One sample every 56 clocks keeps a tooth longer than the longest pulse
  always @(posedge clk_sys) begin
    sampleValid <= genOn && gap == 6'h37;
    gap <= (gap == 6'h37) ? 6'h00 : gap + 6'h01;
    if (genOn && gap == 6'h37) begin
      speedSample <= wave(idx) + 12'h064;
      dirSample <= wave(idx + 6'h10);
      riseNow <= ~idx[5];
      idx <= idx + 6'h01;
    end
  end
  always @(negedge pinLevel) fallRise = riseNow;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr,
                     input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Look at settled outputs mid-cycle; the next rising edge samples them
    @(negedge clk_sys);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(negedge clk_sys);
    end
    check({31'h0, n == 20}, 32'h0);
    rdData = prdata;
    rdErr = pslverr;
    @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic waitPulses(input logic [15:0] n);
    int k;
    k = 0;
    while (pulseCnt < n && k < 40000) begin
      k++;
      @(posedge clk_sys);
    end
    check({31'h0, k == 40000}, 32'h0);
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (95000) @(posedge clk_sys);
    errors++;
    $display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    nvmDone = 1'b1;
    nvmError = 1'b0;
    nvmConfig = 32'h0010_0204;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (12) @(posedge clk_sys);
    apb(1'b0, `REG_STATUS, 32'h0);
    check(rdData & 32'h7, 32'h2);
    apb(1'b0, `REG_CFG, 32'h0);
    check(rdData, 32'h204);
    apb(1'b0, `REG_HYST, 32'h0);
    check(rdData, 32'h010);
    apb(1'b0, 8'h10, 32'h0);
    check({rdData[30:0], rdErr}, 32'h1);
    apb(1'b1, `REG_STATUS, 32'hffff_ffff);
    apb(1'b0, `REG_STATUS, 32'h0);
    check({rdData[2:0], rdErr}, 32'h4);
    $display("Test registers done");
    genOn <= 1'b1;
    waitPulses(16'h0001);
    check({16'h0, lastLen}, 32'h465);
    waitPulses(16'h000a);
    l0 = lastLen;
    check({31'h0, l0 == 16'h0465 || l0 == 16'h08ca}, 32'h1);
    check({31'h0, fallRise}, 32'h0);
    apb(1'b0, `REG_THR, 32'h0);
    check({16'h0, rdData[31:16]}, 32'h320);
    check({31'h0, rdData[15:0] >= 16'h60 && rdData[15:0] <= 16'h68}, 32'h1);
    apb(1'b0, `REG_STATUS, 32'h0);
    check(rdData & 32'h7, 32'h4);
    apb(1'b1, `REG_CFG, 32'h206);
    apb(1'b0, `REG_CFG, 32'h0);
    check(rdData, 32'h206);
    waitPulses(16'h000d);
    check({16'h0, lastLen}, l0 == 16'h0465 ? 32'h8ca : 32'h465);
    check({31'h0, fallRise}, 32'h1);
    apb(1'b1, `REG_CFG, 32'h20e);
    waitPulses(16'h0010);
    check({16'h0, lastLen}, l0 == 16'h0465 ? 32'hd2f : 32'h465);
    $display("Test direction pulses done");
    nvmError <= 1'b1;
    rst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (7200) @(posedge clk_sys);
    check({16'h0, pulseCnt}, 32'h0);
    apb(1'b0, `REG_STATUS, 32'h0);
    check(rdData & 32'hf, 32'hd);
    $display("Test load error lock done");
    print_verdict();
  end
endmodule // tb_crank_speed_direction_core
`default_nettype wire
